// ===== logic/ptmr_pkg.sv
// constants and types for the paired 16/32-bit timer block
// assumes one clock domain and software access over an avalon-mm slave
package ptmr_pkg;
  // word indices on the avalon bus
  localparam logic [3:0] ADDR_CTL_EVEN = 4'h0;
  localparam logic [3:0] ADDR_CTL_ODD = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO = 4'h2;
  localparam logic [3:0] ADDR_CNT_HI = 4'h3;
  localparam logic [3:0] ADDR_PER_LO = 4'h4;
  localparam logic [3:0] ADDR_PER_HI = 4'h5;
  localparam logic [3:0] ADDR_HOLD = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_MASK = 4'h8;
  // control field positions
  localparam int BIT_EN = 15;
  localparam int BIT_SIDL = 13;
  localparam int BIT_GATE = 6;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_JOIN = 3;
  localparam int BIT_CS = 1;
  // implemented bits of each control register
  localparam logic [15:0] CTL_EVEN_MASK = 16'ha07a;
  localparam logic [15:0] CTL_ODD_MASK = 16'ha072;
  // reset values
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] PER_RST = 16'hffff;
  // prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PS_LIM_1 = 8'h00;
  localparam logic [7:0] PS_LIM_8 = 8'h07;
  localparam logic [7:0] PS_LIM_64 = 8'h3f;
  localparam logic [7:0] PS_LIM_256 = 8'hff;
  // status and mask bit positions, then timer indices
  localparam int ST_EVEN = 0;
  localparam int ST_ODD = 1;
  localparam int T_EVEN = 0;
  localparam int T_ODD = 1;

  typedef struct packed {
    logic [1:0][15:0] ctl;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] per;
    logic [1:0][7:0] pre;
    logic [1:0] ext_prev;
    logic [15:0] hold;
    logic [1:0] status;
    logic [1:0] mask;
    logic wait_r;
    logic [31:0] rdata;
    logic irq;
    logic adc;
  } ptmr_state_t;
endpackage : ptmr_pkg

// ===== logic/ptmr_top.sv
// paired timer: two 16-bit synchronous timers or one 32-bit timer,
// with an avalon-mm register slave and a level interrupt
// assumes external pins are already synchronous to CLOCK
// Contract
// - even enable runs even or joined timer
// - join bit forms one 32-bit timer
// - odd control ignored while joined
// - joined uses even clock, odd flag
// - odd count word is upper, even lower
// - 32-bit period match raises interrupt
// - prescale field divides by 1/8/64/256
// - clock source: external rising edge or internal
// - gating only with internal clock
// - halt in idle when bit set
// - control write while enabled clears prescaler
// - adc trigger from odd or joined only
// - timers count synchronously only
// - unimplemented control bits read zero
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
module ptmr_top
  import ptmr_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // device pins
  input wire logic EXT_CLOCK_PIN_EVEN,
  input wire logic EXT_CLOCK_PIN_ODD,
  input wire logic IDLE_MODE,
  // events
  output logic IRQ,
  output logic ADC_TRIGGER
);

  ptmr_state_t s_q;
  ptmr_state_t s_d;

  function automatic logic [7:0] ps_limit(input logic [1:0] sel);
    logic [7:0] r;
    r = PS_LIM_1;
    unique case (sel)
      2'b00: r = PS_LIM_1;
      2'b01: r = PS_LIM_8;
      2'b10: r = PS_LIM_64;
      2'b11: r = PS_LIM_256;
    endcase
    return r;
  endfunction : ps_limit

  // merge low two byte lanes; upper lanes hold no storage
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : merge16

  logic join_w;
  logic [1:0] pin_w;
  logic [1:0] src_w;
  logic [1:0] run_w;
  logic [1:0] tick_w;
  logic [1:0] match_w;
  logic acc_rd;
  logic acc_wr;
  logic [31:0] c32;
  logic [31:0] p32;
  logic [31:0] rd_val;

  assign join_w = s_q.ctl[T_EVEN][BIT_JOIN];
  assign pin_w = {EXT_CLOCK_PIN_ODD, EXT_CLOCK_PIN_EVEN};
  assign c32 = {s_q.cnt[T_ODD], s_q.cnt[T_EVEN]};
  assign p32 = {s_q.per[T_ODD], s_q.per[T_EVEN]};
  // access completes at the edge where waitrequest is seen low
  assign acc_rd = AVS_READ && !s_q.wait_r;
  assign acc_wr = AVS_WRITE && !s_q.wait_r;

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (AVS_ADDRESS)
      ADDR_CTL_EVEN: rd_val[15:0] = s_q.ctl[T_EVEN] & CTL_EVEN_MASK;
      ADDR_CTL_ODD: rd_val[15:0] = s_q.ctl[T_ODD] & CTL_ODD_MASK;
      ADDR_CNT_LO: rd_val[15:0] = s_q.cnt[T_EVEN];
      ADDR_CNT_HI: rd_val[15:0] = s_q.cnt[T_ODD];
      ADDR_PER_LO: rd_val[15:0] = s_q.per[T_EVEN];
      ADDR_PER_HI: rd_val[15:0] = s_q.per[T_ODD];
      ADDR_HOLD: rd_val[15:0] = s_q.hold;
      ADDR_STATUS: rd_val[1:0] = s_q.status;
      ADDR_MASK: rd_val[1:0] = s_q.mask;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    src_w = 2'b00;
    run_w = 2'b00;
    tick_w = 2'b00;
    match_w = 2'b00;
    s_d.ext_prev = pin_w;
    // prescaler per timer; in joined mode only the even one is live
    for (int i = 0; i < 2; i++) begin
      if (s_q.ctl[i][BIT_CS]) begin
        src_w[i] = pin_w[i] && !s_q.ext_prev[i];
      end else if (s_q.ctl[i][BIT_GATE]) begin
        src_w[i] = pin_w[i];
      end else begin
        src_w[i] = 1'b1;
      end
      run_w[i] = s_q.ctl[i][BIT_EN] && !(IDLE_MODE && s_q.ctl[i][BIT_SIDL]);
      if (i == T_ODD && join_w) begin
        run_w[i] = 1'b0;
      end
      if (run_w[i] && src_w[i]) begin
        // a prescaler left high by a rewrite while stopped must not run past a lower limit
        if (s_q.pre[i] >= ps_limit(s_q.ctl[i][BIT_PS_HI:BIT_PS_LO])) begin
          s_d.pre[i] = 8'h00;
          tick_w[i] = 1'b1;
        end else begin
          s_d.pre[i] = s_q.pre[i] + 8'h01;
        end
      end
    end
    // counting
    if (join_w) begin
      if (tick_w[T_EVEN]) begin
        if (c32 == p32) begin
          {s_d.cnt[T_ODD], s_d.cnt[T_EVEN]} = 32'h0000_0000;
          match_w[T_ODD] = 1'b1;
        end else begin
          {s_d.cnt[T_ODD], s_d.cnt[T_EVEN]} = c32 + 32'h0000_0001;
        end
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (tick_w[i]) begin
          if (s_q.cnt[i] == s_q.per[i]) begin
            s_d.cnt[i] = CNT_RST;
            match_w[i] = 1'b1;
          end else begin
            s_d.cnt[i] = s_q.cnt[i] + 16'h0001;
          end
        end
      end
    end
    s_d.adc = match_w[T_ODD];
    // bus handshake: one wait cycle, then the answer
    s_d.wait_r = !((AVS_READ || AVS_WRITE) && s_q.wait_r);
    if (AVS_READ && s_q.wait_r) begin
      s_d.rdata = rd_val;
      if (AVS_ADDRESS == ADDR_CNT_LO && join_w) begin
        s_d.hold = s_q.cnt[T_ODD];
      end
    end
    // clear only bits that software was shown, so late events survive
    if (acc_rd && AVS_ADDRESS == ADDR_STATUS) begin
      s_d.status = s_q.status & ~s_q.rdata[1:0];
    end
    s_d.status = s_d.status | match_w; // set wins over clear
    if (acc_wr) begin
      unique case (AVS_ADDRESS)
        ADDR_CTL_EVEN: begin
          s_d.ctl[T_EVEN] = merge16(s_q.ctl[T_EVEN], AVS_WRITEDATA, AVS_BYTEENABLE)
                            & CTL_EVEN_MASK;
          if (s_q.ctl[T_EVEN][BIT_EN]) begin
            s_d.pre[T_EVEN] = 8'h00;
          end
        end
        ADDR_CTL_ODD: begin
          s_d.ctl[T_ODD] = merge16(s_q.ctl[T_ODD], AVS_WRITEDATA, AVS_BYTEENABLE)
                           & CTL_ODD_MASK;
          if (s_q.ctl[T_ODD][BIT_EN]) begin
            s_d.pre[T_ODD] = 8'h00;
          end
        end
        ADDR_CNT_LO: s_d.cnt[T_EVEN] = merge16(s_q.cnt[T_EVEN], AVS_WRITEDATA, AVS_BYTEENABLE);
        ADDR_CNT_HI: s_d.cnt[T_ODD] = merge16(s_q.cnt[T_ODD], AVS_WRITEDATA, AVS_BYTEENABLE);
        ADDR_PER_LO: s_d.per[T_EVEN] = merge16(s_q.per[T_EVEN], AVS_WRITEDATA, AVS_BYTEENABLE);
        ADDR_PER_HI: s_d.per[T_ODD] = merge16(s_q.per[T_ODD], AVS_WRITEDATA, AVS_BYTEENABLE);
        ADDR_MASK: begin
          if (AVS_BYTEENABLE[0]) begin
            s_d.mask = AVS_WRITEDATA[1:0];
          end
        end
        default: s_d.hold = s_d.hold;
      endcase
    end
    s_d.irq = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      s_q <= '{ctl: {CTL_RST, CTL_RST}, cnt: {CNT_RST, CNT_RST}, per: {PER_RST, PER_RST},
               pre: 16'h0000, ext_prev: 2'b00, hold: CNT_RST, status: 2'b00, mask: 2'b00,
               wait_r: 1'b1, rdata: 32'h0000_0000, irq: 1'b0, adc: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign AVS_READDATA = s_q.rdata;
  assign AVS_WAITREQUEST = s_q.wait_r;
  assign IRQ = s_q.irq;
  assign ADC_TRIGGER = s_q.adc;

  a_bus_one_wait: assert property (@(posedge CLOCK) disable iff (SRST)
    (AVS_READ || AVS_WRITE) && s_q.wait_r |=> !s_q.wait_r ##1 s_q.wait_r)
    else $error("waitrequest did not drop for exactly one cycle");

  a_ctl_reserved_zero: assert property (@(posedge CLOCK) disable iff (SRST)
    AVS_READ && s_q.wait_r && AVS_ADDRESS == ADDR_CTL_ODD |=> (s_q.rdata & ~{16'h0000,
    CTL_ODD_MASK}) == 32'h0000_0000)
    else $error("reserved control bits read nonzero");

  a_adc_odd_only: assert property (@(posedge CLOCK) disable iff (SRST)
    !join_w && tick_w[T_EVEN] && s_q.cnt[T_EVEN] == s_q.per[T_EVEN] && !match_w[T_ODD]
    |=> !ADC_TRIGGER)
    else $error("even timer produced adc trigger");

  a_joined_odd_flag: assert property (@(posedge CLOCK) disable iff (SRST)
    join_w && tick_w[T_EVEN] && c32 == p32 |=> s_q.status[ST_ODD] && ADC_TRIGGER)
    else $error("joined match did not raise odd flag");

  a_joined_odd_idle: assert property (@(posedge CLOCK) disable iff (SRST)
    join_w |-> !tick_w[T_ODD])
    else $error("odd prescaler ran while joined");

  a_match_wraps: assert property (@(posedge CLOCK) disable iff (SRST)
    !join_w && tick_w[T_ODD] && s_q.cnt[T_ODD] == s_q.per[T_ODD] && !acc_wr
    |=> s_q.cnt[T_ODD] == 16'h0000 && s_q.status[ST_ODD])
    else $error("count did not clear on match");

  a_idle_halts: assert property (@(posedge CLOCK) disable iff (SRST)
    IDLE_MODE && s_q.ctl[T_EVEN][BIT_SIDL] && !acc_wr |=> $stable(s_q.cnt[T_EVEN]))
    else $error("timer counted in idle with halt bit set");

  a_div8_rate: assert property (@(posedge CLOCK) disable iff (SRST)
    tick_w[T_EVEN] && s_q.ctl[T_EVEN][BIT_PS_HI:BIT_PS_LO] == 2'b01 && !s_q.ctl[T_EVEN][BIT_CS]
    && !s_q.ctl[T_EVEN][BIT_GATE] && !AVS_WRITE && !IDLE_MODE
    |=> !tick_w[T_EVEN] [*7])
    else $error("1:8 prescale ticked early");

  a_ctl_wr_clears_pre: assert property (@(posedge CLOCK) disable iff (SRST)
    acc_wr && AVS_ADDRESS == ADDR_CTL_EVEN && s_q.ctl[T_EVEN][BIT_EN] |=> s_q.pre[T_EVEN] == 8'h00)
    else $error("control write did not clear prescaler");

  a_hold_latch: assert property (@(posedge CLOCK) disable iff (SRST)
    AVS_READ && s_q.wait_r && AVS_ADDRESS == ADDR_CNT_LO && join_w
    |=> s_q.hold == $past(s_q.cnt[T_ODD]))
    else $error("upper word not latched on low read");

  a_irq_level: assert property (@(posedge CLOCK) disable iff (SRST)
    IRQ |-> |(s_q.status & s_q.mask))
    else $error("interrupt high with no unmasked status");

  a_irq_follows: assert property (@(posedge CLOCK) disable iff (SRST)
    |(s_q.status & s_q.mask)
    |-> IRQ)
    else $error("interrupt low with unmasked status");

  // no disable here: this one looks at the outputs right after reset itself
  a_reset_quiet: assert property (@(posedge CLOCK)
    $past(SRST)
    |-> AVS_WAITREQUEST && !IRQ && !ADC_TRIGGER && AVS_READDATA == 32'h0000_0000)
    else $error("outputs not at rest after reset");

  a_wait_idle_high: assert property (@(posedge CLOCK) disable iff (SRST)
    !AVS_READ && !AVS_WRITE
    |=> AVS_WAITREQUEST)
    else $error("waitrequest low without a request");

  // counting checks; bus writes are excluded since they override the count
  a_even_stopped: assert property (@(posedge CLOCK) disable iff (SRST)
    !s_q.ctl[T_EVEN][BIT_EN] && !acc_wr
    |=> $stable(s_q.cnt[T_EVEN]))
    else $error("even count moved while disabled");

  a_odd_stopped: assert property (@(posedge CLOCK) disable iff (SRST)
    !join_w && !s_q.ctl[T_ODD][BIT_EN] && !acc_wr
    |=> $stable(s_q.cnt[T_ODD]))
    else $error("odd count moved while disabled");

  a_joined_holds: assert property (@(posedge CLOCK) disable iff (SRST)
    join_w && !tick_w[T_EVEN] && !acc_wr
    |=> $stable(c32))
    else $error("joined count moved without an even tick");

  a_joined_steps: assert property (@(posedge CLOCK) disable iff (SRST)
    join_w && tick_w[T_EVEN] && c32 != p32 && !acc_wr
    |=> c32 == $past(c32) + 32'h0000_0001)
    else $error("joined count did not step by one");

  a_joined_no_even: assert property (@(posedge CLOCK) disable iff (SRST)
    join_w && !s_q.status[ST_EVEN]
    |=> !s_q.status[ST_EVEN])
    else $error("even flag set while joined");

  a_single_steps: assert property (@(posedge CLOCK) disable iff (SRST)
    !join_w && tick_w[T_EVEN] && s_q.cnt[T_EVEN] != s_q.per[T_EVEN] && !acc_wr
    |=> s_q.cnt[T_EVEN] == $past(s_q.cnt[T_EVEN]) + 16'h0001)
    else $error("even count did not step by one");

  a_even_wraps: assert property (@(posedge CLOCK) disable iff (SRST)
    !join_w && tick_w[T_EVEN] && s_q.cnt[T_EVEN] == s_q.per[T_EVEN] && !acc_wr
    |=> s_q.cnt[T_EVEN] == 16'h0000 && s_q.status[ST_EVEN])
    else $error("even count did not clear on match");

  // clock source, gating, prescale, idle, adc and control register checks
  a_ext_edge_only: assert property (@(posedge CLOCK) disable iff (SRST)
    s_q.ctl[T_EVEN][BIT_CS] && !(pin_w[T_EVEN] && !s_q.ext_prev[T_EVEN])
    |-> !tick_w[T_EVEN])
    else $error("external source ticked without a rising edge");

  a_gate_low_holds: assert property (@(posedge CLOCK) disable iff (SRST)
    !s_q.ctl[T_EVEN][BIT_CS] && s_q.ctl[T_EVEN][BIT_GATE] && !pin_w[T_EVEN]
    |-> !tick_w[T_EVEN])
    else $error("gated timer ticked with gate low");

  a_gate_ignored: assert property (@(posedge CLOCK) disable iff (SRST)
    s_q.ctl[T_EVEN][BIT_CS] && s_q.ctl[T_EVEN][BIT_GATE] && s_q.ext_prev[T_EVEN]
    |-> !tick_w[T_EVEN])
    else $error("gate level counted with external source");

  a_div1_rate: assert property (@(posedge CLOCK) disable iff (SRST)
    run_w[T_EVEN] && src_w[T_EVEN] && s_q.ctl[T_EVEN][BIT_PS_HI:BIT_PS_LO] == 2'b00
    |-> tick_w[T_EVEN])
    else $error("1:1 prescale missed a tick");

  a_idle_runs: assert property (@(posedge CLOCK) disable iff (SRST)
    IDLE_MODE && s_q.ctl[T_EVEN][BIT_EN] && !s_q.ctl[T_EVEN][BIT_SIDL]
    |-> run_w[T_EVEN])
    else $error("timer stopped in idle with halt bit clear");

  a_odd_wr_pre: assert property (@(posedge CLOCK) disable iff (SRST)
    acc_wr && AVS_ADDRESS == ADDR_CTL_ODD && s_q.ctl[T_ODD][BIT_EN]
    |=> s_q.pre[T_ODD] == 8'h00)
    else $error("odd control write did not clear prescaler");

  a_adc_with_flag: assert property (@(posedge CLOCK) disable iff (SRST)
    ADC_TRIGGER
    |-> s_q.status[ST_ODD])
    else $error("adc trigger without odd flag");

  a_sync_tick: assert property (@(posedge CLOCK) disable iff (SRST)
    tick_w[T_ODD]
    |-> run_w[T_ODD] && src_w[T_ODD])
    else $error("odd timer ticked outside the clock path");

  a_ctl_unused_even: assert property (@(posedge CLOCK) disable iff (SRST)
    AVS_READ && s_q.wait_r && AVS_ADDRESS == ADDR_CTL_EVEN
    |=> (s_q.rdata & ~{16'h0000, CTL_EVEN_MASK}) == 32'h0000_0000)
    else $error("reserved even control bits read nonzero");

  a_ctl_store_clean: assert property (@(posedge CLOCK) disable iff (SRST)
    1'b1
    |-> (s_q.ctl[T_EVEN] & ~CTL_EVEN_MASK) == 16'h0000)
    else $error("reserved even control bits stored");

endmodule : ptmr_top

// ===== test/ptmr_pin_model.sv
// external clock pin source for the even and odd timers
// assumes pins are sampled on the rising edge of CLOCK
`timescale 1ns/10ps
module ptmr_pin_model (
  // clock
  input wire logic CLOCK,
  // pins
  output logic pin_even,
  output logic pin_odd
);
  initial begin
    pin_even = 1'b0;
    pin_odd = 1'b0;
  end
  // one high and one low cycle per edge so each rise is seen alone
  task automatic pulse(input logic odd, input int n);
    repeat (n) begin
      @(posedge CLOCK);
      if (odd) pin_odd <= 1'b1; else pin_even <= 1'b1;
      @(posedge CLOCK);
      if (odd) pin_odd <= 1'b0; else pin_even <= 1'b0;
    end
  endtask : pulse
endmodule : ptmr_pin_model

// ===== test/testbench.sv
// self-checking bench for the paired timer over its avalon-mm slave
// assumes one clock; pins come from the pin model
`timescale 1ns/10ps
module testbench;
  import ptmr_pkg::*;
  logic CLOCK, SRST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IDLE_MODE, IRQ, ADC_TRIGGER;
  logic [3:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
  logic pin_e, pin_o, wr_s;
  logic [31:0] rd_s;
  int miscompares = 0, num_checks = 0, cycles = 0, adc_seen = 0;
  ptmr_top i_dut (.CLOCK(CLOCK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'h3),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .EXT_CLOCK_PIN_EVEN(pin_e), .EXT_CLOCK_PIN_ODD(pin_o), .IDLE_MODE(IDLE_MODE),
    .IRQ(IRQ), .ADC_TRIGGER(ADC_TRIGGER));
  ptmr_pin_model i_pins (.CLOCK(CLOCK), .pin_even(pin_e), .pin_odd(pin_o));
  // mid-cycle copies give the values that the next rising edge samples, free of races
  always @(negedge CLOCK) begin
    wr_s <= AVS_WAITREQUEST;
    rd_s <= AVS_READDATA;
  end
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end
  task automatic results();
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  // the 5000-cycle ceiling is well above the few hundred cycles the scenarios need
  always @(posedge CLOCK) begin
    cycles++;
    if (ADC_TRIGGER === 1'b1) adc_seen++;
    if (cycles > 5000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one access; an idle edge follows so no signal is driven twice in a step
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {16'h0000, d};
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge CLOCK); while (wr_s !== 1'b0);
    rd = rd_s;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLOCK);
  endtask : bus
  task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0000);
    chk(n, e, rd);
  endtask : rchk
  task automatic t_regs();
    rchk("ctl_even_rst", ADDR_CTL_EVEN, 32'h00000000);
    rchk("per_lo_rst", ADDR_PER_LO, 32'h0000ffff);
    rchk("unmapped", 4'h9, 32'h00000000);
    bus(1'b1, ADDR_CTL_EVEN, 16'hffff);
    rchk("ctl_even_bits", ADDR_CTL_EVEN, 32'h0000a07a);
    bus(1'b1, ADDR_CTL_ODD, 16'hffff);
    rchk("ctl_odd_bits", ADDR_CTL_ODD, 32'h0000a072);
    bus(1'b1, ADDR_CTL_EVEN, 16'h0000);
    bus(1'b1, ADDR_CTL_ODD, 16'h0000);
    bus(1'b1, ADDR_CNT_LO, 16'h0000);
    bus(1'b1, ADDR_CNT_HI, 16'h0000);
  endtask : t_regs
  task automatic t_even16();
    bus(1'b1, ADDR_CTL_EVEN, 16'h0002);
    bus(1'b1, ADDR_PER_LO, 16'h0009);
    bus(1'b1, ADDR_MASK, 16'h0001);
    bus(1'b1, ADDR_CTL_EVEN, 16'h8002);
    i_pins.pulse(1'b0, 5);
    rchk("cnt_ext", ADDR_CNT_LO, 32'h00000005);
    IDLE_MODE <= 1'b1;
    bus(1'b1, ADDR_CTL_EVEN, 16'ha002);
    i_pins.pulse(1'b0, 3);
    rchk("cnt_idle", ADDR_CNT_LO, 32'h00000005);
    IDLE_MODE <= 1'b0;
    i_pins.pulse(1'b0, 5);
    rchk("cnt_wrap", ADDR_CNT_LO, 32'h00000000);
    chk("irq_on", 32'h1, {31'h0, IRQ});
    rchk("status_even", ADDR_STATUS, 32'h00000001);
    rchk("status_clr", ADDR_STATUS, 32'h00000000);
    chk("irq_off", 32'h0, {31'h0, IRQ});
    chk("adc_even", 32'h0, adc_seen);
    bus(1'b1, ADDR_CTL_EVEN, 16'h0000);
  endtask : t_even16
  task automatic t_odd_ps();
    bus(1'b1, ADDR_CTL_EVEN, 16'h8010);
    repeat (13) @(posedge CLOCK);
    bus(1'b1, ADDR_CTL_EVEN, 16'h0010);
    rchk("cnt_int8", ADDR_CNT_LO, 32'h00000002);
    bus(1'b1, ADDR_CTL_ODD, 16'h8012);
    i_pins.pulse(1'b1, 16);
    rchk("cnt_ps8", ADDR_CNT_HI, 32'h00000002);
    i_pins.pulse(1'b1, 7);
    rchk("cnt_ps8_hold", ADDR_CNT_HI, 32'h00000002);
    bus(1'b1, ADDR_CTL_ODD, 16'h0000);
    bus(1'b1, ADDR_CNT_HI, 16'h0000);
  endtask : t_odd_ps
  task automatic t_joined();
    bus(1'b1, ADDR_CTL_EVEN, 16'h000a);
    bus(1'b1, ADDR_CTL_ODD, 16'h8000);
    bus(1'b1, ADDR_PER_HI, 16'h0001);
    bus(1'b1, ADDR_PER_LO, 16'h0002);
    bus(1'b1, ADDR_CNT_LO, 16'hfffe);
    adc_seen = 0;
    bus(1'b1, ADDR_CTL_EVEN, 16'h800a);
    i_pins.pulse(1'b0, 2);
    rchk("cnt32_lo", ADDR_CNT_LO, 32'h00000000);
    rchk("cnt32_latch", ADDR_HOLD, 32'h00000001);
    i_pins.pulse(1'b0, 3);
    rchk("cnt32_wrap", ADDR_CNT_HI, 32'h00000000);
    chk("irq_masked", 32'h0, {31'h0, IRQ});
    rchk("status_join", ADDR_STATUS, 32'h00000002);
    chk("adc_join", 32'h1, adc_seen);
  endtask : t_joined
  initial begin
    SRST = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 4'h0;
    AVS_WRITEDATA = 32'h00000000;
    IDLE_MODE = 1'b0;
    repeat (20) @(posedge CLOCK);
    SRST <= 1'b0;
    @(posedge CLOCK);
    t_regs();
    t_even16();
    t_odd_ps();
    t_joined();
    results();
  end
endmodule : testbench
